// ===== hdl/tcm_cfg.svh
`ifndef TCM_CFG_SVH
`define TCM_CFG_SVH

`define TCM_ADDR_CH_ENABLE   8'h35
`define TCM_ADDR_DIODE_FAULT 8'h36
`define TCM_ADDR_LOCAL_REF_H 8'h40
`define TCM_ADDR_LOCAL_REF_L 8'h41
`define TCM_ADDR_FAR1_REF_H  8'h42
`define TCM_ADDR_FAR1_REF_L  8'h43

`define TCM_RST_CH_ENABLE    4'hF
`define TCM_RST_DIODE_FAULT  3'h0
`define TCM_RST_REF_BYTE     8'h00
`define TCM_RST_REF_FRAC     4'h0
`define TCM_RST_CH           2'h0

`define TCM_RD_NONE          8'h00
`define TCM_CH_LOCAL         2'h0
`define TCM_EN_W             4
`define TCM_FAULT_LSB        1
`define TCM_FAULT_MSB        3
`define TCM_FRAC_LSB         4
`define TCM_FRAC_MSB         7
`define TCM_RSVD_HI_W        4
`define TCM_RSVD_FRAC_W      4

`endif

// ===== hdl/tcm_pkg.sv
package tcm_pkg;

   typedef logic [1:0] tcm_ch_t;

   typedef enum logic [1:0]
   {
      TCM_SEQ_IDLE  = 2'b00,
      TCM_SEQ_START = 2'b01,
      TCM_SEQ_WAIT  = 2'b10
   } tcm_seq_e;

   // Signed integer byte then fraction nibble; the low nibble is implied zero
   typedef struct packed
   {
      logic [7:0] whole;
      logic [3:0] frac;
   } tcm_ref_s;

   typedef struct packed
   {
      tcm_ref_s local_ref;
      tcm_ref_s far_one_ref;
   } tcm_refs_s;

   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tcm_req_s;

   // Next enabled channel after cur, wrapping; returns cur when it is the only one
   function automatic tcm_ch_t tcm_next_ch(input tcm_ch_t cur, input logic [3:0] en);
      tcm_ch_t c;
      tcm_ch_t r;
      c = cur;
      r = cur;
      for (int i = 1; i <= 4; i++)
      begin
         c = tcm_ch_t'(cur + tcm_ch_t'(i));
         if (en[c] && r == cur && !(i < 4 && c == cur))
            r = c;
      end
      for (int i = 1; i < 4; i++)
      begin
         c = tcm_ch_t'(cur + tcm_ch_t'(i));
         if (en[c])
         begin
            r = c;
            break;
         end
      end
      return r;
   endfunction : tcm_next_ch

endpackage : tcm_pkg

// ===== hdl/tcm_seq.sv
`timescale 1ns/100ps
`include "tcm_cfg.svh"

module tcm_seq
(
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic [3:0]       ch_enable,
   input  wire logic             conv_done,
   output logic                  conv_start,
   output tcm_pkg::tcm_ch_t      conv_ch
);

   tcm_pkg::tcm_seq_e state_q;
   tcm_pkg::tcm_seq_e state_d;
   tcm_pkg::tcm_ch_t  ch_q;
   tcm_pkg::tcm_ch_t  ch_d;
   logic              start_q;
   logic              any_en;
   logic              cur_en;
   tcm_pkg::tcm_ch_t  nxt_ch;

   assign any_en = |ch_enable;
   assign cur_en = ch_enable[ch_q];
   assign nxt_ch = tcm_pkg::tcm_next_ch(ch_q, ch_enable);

   // Disabled channels are skipped by picking the next enabled one
   always_comb
   begin
      state_d = state_q;
      ch_d    = ch_q;
      case (state_q)
         tcm_pkg::TCM_SEQ_IDLE:
         begin
            if (any_en)
            begin
               state_d = tcm_pkg::TCM_SEQ_START;
               ch_d    = cur_en ? ch_q : nxt_ch;
            end
         end
         tcm_pkg::TCM_SEQ_START:
            state_d = tcm_pkg::TCM_SEQ_WAIT;
         tcm_pkg::TCM_SEQ_WAIT:
         begin
            if (conv_done)
            begin
               ch_d    = nxt_ch;
               state_d = any_en ? tcm_pkg::TCM_SEQ_START : tcm_pkg::TCM_SEQ_IDLE;
            end
         end
         default:
            state_d = tcm_pkg::TCM_SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= tcm_pkg::TCM_SEQ_IDLE;
         ch_q    <= `TCM_RST_CH;
         start_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         ch_q    <= ch_d;
         start_q <= (state_d == tcm_pkg::TCM_SEQ_START);
      end
   end

   assign conv_start = start_q;
   assign conv_ch    = ch_q;

   a_start_enabled_ch: assert property (@(posedge clock) disable iff (!rstn)
      start_q && !$past(state_q == tcm_pkg::TCM_SEQ_IDLE) |-> $past(ch_enable[ch_d]))
      else $error("conversion started on a disabled channel");

   a_start_one_pulse: assert property (@(posedge clock) disable iff (!rstn)
      start_q |=> !start_q)
      else $error("conversion start longer than one cycle");

endmodule : tcm_seq

// ===== hdl/tcm_regs.sv
// Functional notes
// - A disabled channel is skipped; conversion moves on to the next enabled one.
// - A disabled remote channel gets no diode fault detection update.
// - All four channel enable bits reset to one (register value 0Fh).
// - Local enable gates only conversion; local channel has no diode check.
// - Remote 1..3 fault bits set on open or short detection; reset to zero.
// - Reference high byte: sign plus integer degrees, read/write, resets to zero.
// - Reference low byte: four fraction bits high, low nibble reads zero.
// - Stored local and channel 1 references feed the highest-temperature choice.
// - Toggling extended format leaves stored limit and reference values untouched.
`timescale 1ns/100ps
`include "tcm_cfg.svh"

module tcm_regs
(
   input  wire logic                clock,
   input  wire logic                rstn,
   input  wire tcm_pkg::tcm_req_s   reg_req,
   output logic [7:0]               reg_rdata,
   input  wire logic                ext_format,
   input  wire logic                conv_done,
   input  wire logic                fault_detected,
   output logic                     conv_start,
   output tcm_pkg::tcm_ch_t         conv_ch,
   output logic [3:0]               ch_enable,
   output logic [3:1]               diode_fault,
   output tcm_pkg::tcm_refs_s       ref_temps
);

   logic [3:0]         enable_q;
   logic [3:1]         fault_q;
   logic [3:1]         fault_d;
   tcm_pkg::tcm_refs_s refs_q;
   logic [7:0]         rdata_q;
   logic [7:0]         rdata_d;
   tcm_pkg::tcm_ch_t   seq_ch;
   logic               seq_start;

   // One write decode shared by every register strobe
   function automatic logic wr_hit(input tcm_pkg::tcm_req_s r, input logic [7:0] a);
      return r.wr && r.addr == a;
   endfunction : wr_hit

   // Fraction nibble sits high; the unused low nibble always reads zero
   function automatic logic [7:0] frac_byte(input logic [3:0] f);
      return {f, {`TCM_RSVD_FRAC_W{1'b0}}};
   endfunction : frac_byte

   wire wr_enable  = wr_hit(reg_req, `TCM_ADDR_CH_ENABLE);
   wire wr_fault   = wr_hit(reg_req, `TCM_ADDR_DIODE_FAULT);
   wire wr_loc_h   = wr_hit(reg_req, `TCM_ADDR_LOCAL_REF_H);
   wire wr_loc_l   = wr_hit(reg_req, `TCM_ADDR_LOCAL_REF_L);
   wire wr_far1_h  = wr_hit(reg_req, `TCM_ADDR_FAR1_REF_H);
   wire wr_far1_l  = wr_hit(reg_req, `TCM_ADDR_FAR1_REF_L);

   tcm_seq u_seq
   (
      .clock      (clock),
      .rstn       (rstn),
      .ch_enable  (enable_q),
      .conv_done  (conv_done),
      .conv_start (seq_start),
      .conv_ch    (seq_ch)
   );

   // A fault result belongs to the channel in conversion; local has no diode
   wire       fault_chk   = conv_done && seq_ch != `TCM_CH_LOCAL;
   wire       fault_gate  = fault_chk && enable_q[seq_ch];
   wire [3:0] fault_onehot = 4'h1 << seq_ch;
   wire [3:1] fault_set   = (fault_gate && fault_detected) ?
                            fault_onehot[`TCM_FAULT_MSB:`TCM_FAULT_LSB] : 3'h0;

   // Set wins over a host write of zero, so no detection is lost
   always_comb
   begin
      fault_d = fault_q;
      if (wr_fault)
         fault_d = reg_req.wdata[`TCM_FAULT_MSB:`TCM_FAULT_LSB];
      fault_d = fault_d | fault_set;
   end

   // Unmapped addresses read as zero
   always_comb
   begin
      case (reg_req.addr)
         `TCM_ADDR_CH_ENABLE:
            rdata_d = {{`TCM_RSVD_HI_W{1'b0}}, enable_q};
         `TCM_ADDR_DIODE_FAULT:
            rdata_d = {{`TCM_RSVD_HI_W{1'b0}}, fault_q, 1'b0};
         `TCM_ADDR_LOCAL_REF_H:
            rdata_d = refs_q.local_ref.whole;
         `TCM_ADDR_LOCAL_REF_L:
            rdata_d = frac_byte(refs_q.local_ref.frac);
         `TCM_ADDR_FAR1_REF_H:
            rdata_d = refs_q.far_one_ref.whole;
         `TCM_ADDR_FAR1_REF_L:
            rdata_d = frac_byte(refs_q.far_one_ref.frac);
         default:
            rdata_d = `TCM_RD_NONE;
      endcase
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         enable_q <= `TCM_RST_CH_ENABLE;
         fault_q  <= `TCM_RST_DIODE_FAULT;
         rdata_q  <= `TCM_RD_NONE;
      end
      else
      begin
         if (wr_enable)
            enable_q <= reg_req.wdata[`TCM_EN_W-1:0];
         fault_q <= fault_d;
         if (reg_req.rd)
            rdata_q <= rdata_d;
      end
   end

   // The format select never reaches these flops: values are kept exactly as written
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         refs_q.local_ref.whole   <= `TCM_RST_REF_BYTE;
         refs_q.local_ref.frac    <= `TCM_RST_REF_FRAC;
         refs_q.far_one_ref.whole <= `TCM_RST_REF_BYTE;
         refs_q.far_one_ref.frac  <= `TCM_RST_REF_FRAC;
      end
      else
      begin
         if (wr_loc_h)
            refs_q.local_ref.whole <= reg_req.wdata;
         if (wr_loc_l)
            refs_q.local_ref.frac <= reg_req.wdata[`TCM_FRAC_MSB:`TCM_FRAC_LSB];
         if (wr_far1_h)
            refs_q.far_one_ref.whole <= reg_req.wdata;
         if (wr_far1_l)
            refs_q.far_one_ref.frac <= reg_req.wdata[`TCM_FRAC_MSB:`TCM_FRAC_LSB];
      end
   end

   assign reg_rdata   = rdata_q;
   assign conv_start  = seq_start;
   assign conv_ch     = seq_ch;
   assign ch_enable   = enable_q;
   assign diode_fault = fault_q;
   assign ref_temps   = refs_q;

   sequence s_ref_quiet;
      !(wr_loc_h || wr_loc_l || wr_far1_h || wr_far1_l);
   endsequence

   sequence s_loc_h_written;
      wr_loc_h ##1 !reg_req.wr;
   endsequence

   sequence s_loc_h_read;
      reg_req.rd && !reg_req.wr && reg_req.addr == `TCM_ADDR_LOCAL_REF_H;
   endsequence

   a_fault_set_wins: assert property (@(posedge clock) disable iff (!rstn)
      |fault_set |=> (fault_q & $past(fault_set)) == $past(fault_set))
      else $error("detected diode fault not recorded");

   a_fault_disabled: assert property (@(posedge clock) disable iff (!rstn)
      !wr_fault && !enable_q[seq_ch] && conv_done |=> $stable(fault_q))
      else $error("fault flag moved for a disabled channel");

   a_fault_no_local: assert property (@(posedge clock) disable iff (!rstn)
      !wr_fault && conv_done && seq_ch == `TCM_CH_LOCAL |=> $stable(fault_q))
      else $error("local conversion changed a diode fault flag");

   a_rsvd_read_zero: assert property (@(posedge clock) disable iff (!rstn)
      reg_req.rd && reg_req.addr == `TCM_ADDR_DIODE_FAULT |=>
         reg_rdata[0] == 1'b0 && reg_rdata[7:4] == 4'h0)
      else $error("reserved fault bits read non-zero");

   a_frac_low_zero: assert property (@(posedge clock) disable iff (!rstn)
      reg_req.rd && (reg_req.addr == `TCM_ADDR_LOCAL_REF_L ||
         reg_req.addr == `TCM_ADDR_FAR1_REF_L) |=> reg_rdata[3:0] == 4'h0)
      else $error("fraction low nibble not zero");

   a_ref_write_back: assert property (@(posedge clock) disable iff (!rstn)
      s_loc_h_written ##1 s_loc_h_read |=> reg_rdata == $past(reg_req.wdata, 3))
      else $error("local reference high byte did not read back");

   a_far_high_write: assert property (@(posedge clock) disable iff (!rstn)
      wr_far1_h |=> ref_temps.far_one_ref.whole == $past(reg_req.wdata))
      else $error("channel 1 reference high byte not stored");

   a_far_frac_write: assert property (@(posedge clock) disable iff (!rstn)
      wr_far1_l |=>
         ref_temps.far_one_ref.frac == $past(reg_req.wdata[`TCM_FRAC_MSB:`TCM_FRAC_LSB]))
      else $error("channel 1 reference fraction not stored");

   a_enable_write: assert property (@(posedge clock) disable iff (!rstn)
      wr_enable |=> ch_enable == $past(reg_req.wdata[`TCM_EN_W-1:0]))
      else $error("channel enable write not stored");

   a_fault_host_write: assert property (@(posedge clock) disable iff (!rstn)
      wr_fault && !(|fault_set) |=>
         diode_fault == $past(reg_req.wdata[`TCM_FAULT_MSB:`TCM_FAULT_LSB]))
      else $error("diode fault write not stored");

   // Only a host write may drop a flag; reading leaves it set
   a_fault_sticky: assert property (@(posedge clock) disable iff (!rstn)
      !wr_fault |=> (diode_fault & $past(diode_fault)) == $past(diode_fault))
      else $error("diode fault flag dropped without a write");

   a_unmapped_zero: assert property (@(posedge clock) disable iff (!rstn)
      reg_req.rd && !(reg_req.addr inside {`TCM_ADDR_CH_ENABLE, `TCM_ADDR_DIODE_FAULT,
         `TCM_ADDR_LOCAL_REF_H, `TCM_ADDR_LOCAL_REF_L, `TCM_ADDR_FAR1_REF_H,
         `TCM_ADDR_FAR1_REF_L}) |=> reg_rdata == `TCM_RD_NONE)
      else $error("unmapped address read non-zero");

   a_rdata_hold: assert property (@(posedge clock) disable iff (!rstn)
      !reg_req.rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   a_ref_fmt_stable: assert property (@(posedge clock) disable iff (!rstn)
      $changed(ext_format) ##0 s_ref_quiet |=> $stable(ref_temps))
      else $error("format change altered stored references");

   a_enable_reset: assert property (@(posedge clock)
      $rose(rstn) |-> ch_enable == `TCM_RST_CH_ENABLE)
      else $error("channel enables not all set after reset");

endmodule : tcm_regs

// ===== tb/tcm_conv_model.sv
`timescale 1ns/100ps

module tcm_conv_model
(
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             conv_start,
   input  wire tcm_pkg::tcm_ch_t conv_ch,
   input  wire logic [3:0]       fault_mask,
   input  wire logic [3:0]       delay,
   output logic                  conv_done,
   output logic                  fault_detected
);
   logic             busy_q;
   logic [3:0]       cnt_q;
   tcm_pkg::tcm_ch_t ch_q;

   // Outside a result the fault line shows the wrong level, so a design that samples early fails
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         busy_q         <= 1'b0;
         cnt_q          <= 4'h0;
         ch_q           <= 2'h0;
         conv_done      <= 1'b0;
         fault_detected <= 1'b0;
      end
      else
      begin
         conv_done      <= 1'b0;
         fault_detected <= ~fault_mask[ch_q];
         if (conv_start)
         begin
            busy_q <= 1'b1;
            cnt_q  <= delay;
            ch_q   <= conv_ch;
         end
         else if (busy_q && cnt_q == 4'h0)
         begin
            conv_done      <= 1'b1;
            fault_detected <= fault_mask[ch_q];
            busy_q         <= 1'b0;
         end
         else if (busy_q)
            cnt_q <= cnt_q - 4'h1;
      end
   end
endmodule : tcm_conv_model

// ===== tb/test_tcm_regs.sv
`timescale 1ns/100ps
`include "tcm_cfg.svh"

module test_tcm_regs;
   logic                clock = 1'b0;
   logic                rstn  = 1'b0;
   tcm_pkg::tcm_req_s   req   = '0;
   logic                ext_format = 1'b0;
   logic [3:0]          fault_mask = 4'h0;
   logic [3:0]          delay      = 4'h1;
   logic [7:0]          reg_rdata;
   logic                conv_done, fault_detected, conv_start;
   tcm_pkg::tcm_ch_t    conv_ch, ch;
   logic [3:0]          ch_enable;
   logic [3:1]          diode_fault;
   tcm_pkg::tcm_refs_s  ref_temps;
   int                  errors = 0;
   int                  check_count = 0;
   int                  cycles = 0;

   tcm_regs tcm_regs_inst (.clock(clock), .rstn(rstn), .reg_req(req), .reg_rdata(reg_rdata),
      .ext_format(ext_format), .conv_done(conv_done), .fault_detected(fault_detected),
      .conv_start(conv_start), .conv_ch(conv_ch), .ch_enable(ch_enable),
      .diode_fault(diode_fault), .ref_temps(ref_temps));
   tcm_conv_model tcm_conv_model_inst (.clock(clock), .rstn(rstn), .conv_start(conv_start),
      .conv_ch(conv_ch), .fault_mask(fault_mask), .delay(delay), .conv_done(conv_done),
      .fault_detected(fault_detected));

   initial
   begin
      forever #5 clock = ~clock;
   end

   // Whole run needs only a couple of hundred cycles; the ceiling leaves ample margin
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         give_verdict();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock) req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clock) req = '0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clock) req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clock) req = '0;
      @(negedge clock) check(reg_rdata, exp);
   endtask : rd

   task automatic wait_start(output tcm_pkg::tcm_ch_t c);
      int n;
      n = 0;
      @(negedge clock);
      while (conv_start !== 1'b1 && n < 200)
      begin
         n++;
         @(negedge clock);
      end
      check({7'h00, conv_start}, 8'h01);
      c = conv_ch;
   endtask : wait_start

   task automatic reset_values;
      rd(`TCM_ADDR_CH_ENABLE, 8'h0F);
      rd(`TCM_ADDR_DIODE_FAULT, 8'h00);
      rd(`TCM_ADDR_LOCAL_REF_H, 8'h00);
      rd(`TCM_ADDR_LOCAL_REF_L, 8'h00);
      rd(`TCM_ADDR_FAR1_REF_H, 8'h00);
      rd(`TCM_ADDR_FAR1_REF_L, 8'h00);
      rd(8'h37, 8'h00);
   endtask : reset_values

   task automatic reserved_bits;
      wr(`TCM_ADDR_CH_ENABLE, 8'hFF);
      rd(`TCM_ADDR_CH_ENABLE, 8'h0F);
      wr(`TCM_ADDR_DIODE_FAULT, 8'hFF);
      rd(`TCM_ADDR_DIODE_FAULT, 8'h0E);
      wr(`TCM_ADDR_DIODE_FAULT, 8'h00);
      rd(`TCM_ADDR_DIODE_FAULT, 8'h00);
   endtask : reserved_bits

   task automatic references;
      wr(`TCM_ADDR_LOCAL_REF_H, 8'hA5);
      rd(`TCM_ADDR_LOCAL_REF_H, 8'hA5);
      wr(`TCM_ADDR_LOCAL_REF_L, 8'hFF);
      wr(`TCM_ADDR_FAR1_REF_H, 8'h81);
      wr(`TCM_ADDR_FAR1_REF_L, 8'h3C);
      rd(`TCM_ADDR_LOCAL_REF_H, 8'hA5);
      rd(`TCM_ADDR_LOCAL_REF_L, 8'hF0);
      rd(`TCM_ADDR_FAR1_REF_L, 8'h30);
      check(ref_temps.local_ref.whole, 8'hA5);
      check({4'h0, ref_temps.local_ref.frac}, 8'h0F);
      check(ref_temps.far_one_ref.whole, 8'h81);
      check({4'h0, ref_temps.far_one_ref.frac}, 8'h03);
      @(negedge clock) ext_format = 1'b1;
      rd(`TCM_ADDR_LOCAL_REF_H, 8'hA5);
      rd(`TCM_ADDR_FAR1_REF_H, 8'h81);
      // Host now writes in the extended encoding itself
      wr(`TCM_ADDR_FAR1_REF_H, 8'hC0);
      @(negedge clock) ext_format = 1'b0;
      rd(`TCM_ADDR_FAR1_REF_H, 8'hC0);
   endtask : references

   task automatic remote_pair;
      tcm_pkg::tcm_ch_t prev;
      fault_mask = 4'hE;
      delay      = 4'h5;
      wr(`TCM_ADDR_CH_ENABLE, 8'h0A);
      wait_start(prev);
      wr(`TCM_ADDR_DIODE_FAULT, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         wait_start(ch);
         check({6'h00, ch}, (prev == 2'h1) ? 8'h03 : 8'h01);
         prev = ch;
      end
      rd(`TCM_ADDR_DIODE_FAULT, 8'h0A);
      check({4'h0, diode_fault, 1'b0}, 8'h0A);
   endtask : remote_pair

   task automatic local_only;
      delay = 4'h0;
      wr(`TCM_ADDR_CH_ENABLE, 8'h01);
      wait_start(ch);
      wr(`TCM_ADDR_DIODE_FAULT, 8'h00);
      for (int i = 0; i < 3; i++)
      begin
         wait_start(ch);
         check({6'h00, ch}, 8'h00);
      end
      rd(`TCM_ADDR_DIODE_FAULT, 8'h00);
      check({4'h0, ch_enable}, 8'h01);
   endtask : local_only

   // Second reset in mid-run; no faults may be found before the reads
   task automatic mid_reset;
      fault_mask = 4'h0;
      @(negedge clock) rstn = 1'b0;
      repeat (2) @(negedge clock);
      rstn = 1'b1;
      rd(`TCM_ADDR_CH_ENABLE, 8'h0F);
      rd(`TCM_ADDR_DIODE_FAULT, 8'h00);
      rd(`TCM_ADDR_LOCAL_REF_H, 8'h00);
   endtask : mid_reset

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   initial
   begin
      repeat (12) @(negedge clock);
      rstn = 1'b1;
      reset_values();
      reserved_bits();
      references();
      remote_pair();
      local_only();
      mid_reset();
      give_verdict();
   end
endmodule : test_tcm_regs
